/* hdl/cpu_supervisor_reset_ctl.sv */
// Processor supervisor: reset stretch, watchdog, RAM enables, interrupt and serial pins.
`timescale 1ns/10ps
// Overview of operation
// - A failing supply holds the processor reset active.
// - Reset stays active 250 ms after the supply recovers.
// - A debounced button press gives a reset of at least 250 ms.
// - A watchdog timeout without a kick forces the reset active.
// - Serial data moves on the host serial clock.
// - RAM is enabled only while the RAM select input is low.
// - Interrupt is high while any pending bit and its enable are set.
// - Interrupt works the same on main or battery supply.
// - Each byte select output needs its byte input and RAM select low.
// - Reset pin is open-drain; an outside low acts as button.
// - Command byte: bits 0 to 6 address, bit 7 set means write.
module cpu_supervisor_reset_ctl #(
	parameter int STRETCH_CYC = supervisor_pkg::STRETCH_CYC,
	parameter int DEBOUNCE_CYC = supervisor_pkg::DEBOUNCE_CYC,
	parameter int WDOG_CYC = supervisor_pkg::WDOG_CYC,
	parameter int IRQ_W = 8
) (
	// System clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Supply monitor and watchdog strobe.
	input wire logic supplyFail,
	input wire logic watchdog_kick_n,
	// Open-drain processor reset pin.
	input wire logic cpu_reset_in,
	output logic cpu_reset_out,
	output logic cpu_reset_oe,
	// External RAM byte enables.
	input wire logic ram_select_in_n,
	input wire logic upper_byte_sel_n,
	input wire logic lower_byte_sel_n,
	output logic low_ram_select_n,
	output logic high_ram_select_n,
	// Interrupt sources and output.
	input wire logic [IRQ_W-1:0] irqPending,
	input wire logic [IRQ_W-1:0] irqEnable,
	output logic irq_out,
	// Three-wire serial port.
	input wire logic serial_clock_in,
	input wire logic serial_chip_sel,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe,
	// Received command in the system domain.
	output supervisor_pkg::cmd_t cmdOut,
	output logic [7:0] cmdData,
	output logic cmdValid
);
	localparam logic [supervisor_pkg::CNT_W-1:0] STRETCH_LAST =
		supervisor_pkg::CNT_W'(STRETCH_CYC - 1);
	localparam logic [supervisor_pkg::CNT_W-1:0] DEB_LAST =
		supervisor_pkg::CNT_W'(DEBOUNCE_CYC - 1);
	localparam logic [supervisor_pkg::CNT_W-1:0] WDOG_LAST =
		supervisor_pkg::CNT_W'(WDOG_CYC - 1);

	// ---- Link domain, clocked by the host serial clock.
	logic [3:0] bitCnt_ff, nxt_bitCnt;
	logic [supervisor_pkg::FRAME_BITS-1:0] shift_ff, nxt_shift;
	logic frameTgl_ff, nxt_frameTgl;
	logic [supervisor_pkg::FRAME_BITS-1:0] frameHold_ff, nxt_frameHold;
	logic dataOe_ff, nxt_dataOe;
	logic dataOut_ff;

	// Shift bits in LSB first; the frame completes on the sixteenth rising edge.
	always_comb begin
		nxt_shift = {serial_data_in, shift_ff[supervisor_pkg::FRAME_BITS-1:1]};
		nxt_bitCnt = bitCnt_ff + 4'h1;
		nxt_frameTgl = frameTgl_ff;
		nxt_frameHold = frameHold_ff;
		nxt_dataOe = dataOe_ff;
		if (bitCnt_ff == supervisor_pkg::CMD_LAST) begin
			nxt_dataOe = ~serial_data_in;
		end
		if (bitCnt_ff == supervisor_pkg::FRAME_LAST) begin
			nxt_frameHold = nxt_shift;
			nxt_frameTgl = ~frameTgl_ff;
			nxt_dataOe = 1'b0;
		end
	end

	always_ff @(posedge serial_clock_in or negedge serial_chip_sel) begin
		if (!serial_chip_sel) begin
			bitCnt_ff <= 4'h0;
			shift_ff <= '0;
			dataOe_ff <= 1'b0;
			dataOut_ff <= 1'b0;
		end else begin
			bitCnt_ff <= nxt_bitCnt;
			shift_ff <= nxt_shift;
			dataOe_ff <= nxt_dataOe;
			dataOut_ff <= 1'b0;
		end
	end

	// The completed frame and its toggle outlive chip select.
	always_ff @(posedge serial_clock_in) begin
		if (sys_rst) begin
			frameTgl_ff <= 1'b0;
			frameHold_ff <= '0;
		end else begin
			frameTgl_ff <= nxt_frameTgl;
			frameHold_ff <= nxt_frameHold;
		end
	end

	assign serial_data_oe = dataOe_ff;
	assign serial_data_out = dataOut_ff;

	// ---- System domain.
	supervisor_pkg::pins_t syn;
	pin_sync #(
		.W(supervisor_pkg::SYNC_W),
		.RST_VAL(supervisor_pkg::PIN_RST)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.rawIn({frameTgl_ff, watchdog_kick_n, cpu_reset_in, ram_select_in_n,
			upper_byte_sel_n, lower_byte_sel_n, supplyFail}),
		.stableOut(syn)
	);

	logic [supervisor_pkg::CNT_W-1:0] stretchCnt_ff, nxt_stretchCnt;
	logic [supervisor_pkg::CNT_W-1:0] debCnt_ff, nxt_debCnt;
	logic [supervisor_pkg::CNT_W-1:0] wdCnt_ff, nxt_wdCnt;
	logic active_ff, nxt_active;
	logic armed_ff, nxt_armed;
	logic kickPrev_ff, tglPrev_ff;
	logic lowSel_ff, highSel_ff, irq_ff, rstOut_ff;
	supervisor_pkg::cmd_t cmd_ff, nxt_cmd;
	logic [7:0] data_ff, nxt_data;
	logic valid_ff, nxt_valid;
	logic btnAccept, wdExpire, kickFall, cause, stretchDone, frameSeen;

	// Event decode from the filtered pins.
	always_comb begin
		kickFall = kickPrev_ff & ~syn.kickN;
		frameSeen = tglPrev_ff ^ syn.frameTgl;
		btnAccept = armed_ff & ~active_ff & ~syn.resetPinN & (debCnt_ff == DEB_LAST);
		wdExpire = ~active_ff & ~kickFall & (wdCnt_ff == WDOG_LAST);
		stretchDone = active_ff & (stretchCnt_ff == STRETCH_LAST);
		cause = syn.supplyFail | btnAccept | wdExpire;
	end

	// Reset stretch, button debounce and watchdog counters.
	always_comb begin
		nxt_active = active_ff;
		nxt_stretchCnt = stretchCnt_ff;
		if (cause) begin
			nxt_active = 1'b1;
			nxt_stretchCnt = '0;
		end else if (stretchDone) begin
			nxt_active = 1'b0;
		end else if (active_ff) begin
			nxt_stretchCnt = stretchCnt_ff + 1'b1;
		end
		nxt_armed = syn.resetPinN ? 1'b1 : ((active_ff | btnAccept) ? 1'b0 : armed_ff);
		if (armed_ff & ~active_ff & ~syn.resetPinN & ~btnAccept) begin
			nxt_debCnt = debCnt_ff + 1'b1;
		end else begin
			nxt_debCnt = '0;
		end
		if (kickFall | active_ff | wdExpire) begin
			nxt_wdCnt = '0;
		end else begin
			nxt_wdCnt = wdCnt_ff + 1'b1;
		end
		// Received frame capture on toggle change.
		nxt_valid = frameSeen;
		nxt_cmd = frameSeen ? supervisor_pkg::cmd_t'(syn_frame_cmd()) : cmd_ff;
		nxt_data = frameSeen ?
			frameHold_ff[supervisor_pkg::FRAME_BITS-1:supervisor_pkg::RW_BIT+1] : data_ff;
	end

	// Command byte view of the held frame, read only after its toggle settled.
	function automatic logic [7:0] syn_frame_cmd();
		syn_frame_cmd = frameHold_ff[supervisor_pkg::RW_BIT:0];
	endfunction

	// Registered state of the system domain.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			active_ff <= 1'b1;
			stretchCnt_ff <= '0;
			debCnt_ff <= '0;
			armed_ff <= 1'b0;
			wdCnt_ff <= '0;
			kickPrev_ff <= 1'b1;
			tglPrev_ff <= 1'b0;
			cmd_ff <= '0;
			data_ff <= 8'h00;
			valid_ff <= 1'b0;
			lowSel_ff <= 1'b1;
			highSel_ff <= 1'b1;
			irq_ff <= 1'b0;
			rstOut_ff <= 1'b0;
		end else begin
			active_ff <= nxt_active;
			stretchCnt_ff <= nxt_stretchCnt;
			debCnt_ff <= nxt_debCnt;
			armed_ff <= nxt_armed;
			wdCnt_ff <= nxt_wdCnt;
			kickPrev_ff <= syn.kickN;
			tglPrev_ff <= syn.frameTgl;
			cmd_ff <= nxt_cmd;
			data_ff <= nxt_data;
			valid_ff <= nxt_valid;
			lowSel_ff <= syn.ramSelN | syn.lowerN;
			highSel_ff <= syn.ramSelN | syn.upperN;
			irq_ff <= |(irqPending & irqEnable);
			rstOut_ff <= 1'b0;
		end
	end

	assign cpu_reset_oe = active_ff;
	assign cpu_reset_out = rstOut_ff;
	assign low_ram_select_n = lowSel_ff;
	assign high_ram_select_n = highSel_ff;
	assign irq_out = irq_ff;
	assign cmdOut = cmd_ff;
	assign cmdData = data_ff;
	assign cmdValid = valid_ff;

	// Checks on the system domain, plus one on the link domain.
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_FAIL_RESET: assert property (syn.supplyFail |=> cpu_reset_oe)
		else $error("Supply fail did not assert reset.");
	AST_RECOVER_HOLD: assert property ($fell(syn.supplyFail) |-> cpu_reset_oe [*8])
		else $error("Reset released too soon after supply recovery.");
	AST_STRETCH_LEN: assert property ($fell(cpu_reset_oe) |-> $past(stretchCnt_ff) == STRETCH_LAST)
		else $error("Reset released before full stretch.");
	AST_BUTTON: assert property (btnAccept |=> cpu_reset_oe && stretchCnt_ff == '0)
		else $error("Accepted press did not start reset.");
	AST_WDOG: assert property (wdExpire |=> cpu_reset_oe ##1 wdCnt_ff == '0)
		else $error("Watchdog expiry did not reset.");
	AST_KICK: assert property (kickFall && !active_ff |=> wdCnt_ff == '0)
		else $error("Kick did not restart watchdog.");
	AST_RAM_OFF: assert property (syn.ramSelN |=> low_ram_select_n && high_ram_select_n)
		else $error("RAM enabled without RAM select.");
	AST_HIGH_SEL: assert property (!high_ram_select_n |-> !$past(syn.upperN) && !$past(syn.ramSelN))
		else $error("High byte enable without its inputs.");
	AST_IRQ: assert property (|(irqPending & irqEnable) |=> irq_out)
		else $error("Interrupt not raised for enabled pending bit.");
	AST_OPEN_DRAIN: assert property (cpu_reset_oe |-> !cpu_reset_out)
		else $error("Reset pin driven high.");
	AST_LINK_OE: assert property (@(posedge serial_clock_in) disable iff (!serial_chip_sel)
		serial_data_oe |-> bitCnt_ff > supervisor_pkg::CMD_LAST)
		else $error("Data driven during command byte.");

	CV_RECOVER: cover property ($fell(syn.supplyFail) ##[1:8] cpu_reset_oe);
	CV_BUTTON: cover property (btnAccept);
	CV_WDOG: cover property (wdExpire);
	CV_FRAME: cover property (cmdValid);
endmodule

/* hdl/pin_sync.sv */
// Three-stage input synchroniser with a two-stage agreement filter.
`timescale 1ns/10ps
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Raw and filtered levels.
	input wire logic [W-1:0] rawIn,
	output logic [W-1:0] stableOut
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] out_ff;
	logic [W-1:0] nxt_out;

	// The filtered level moves only once stages two and three agree.
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_comb begin
			nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
		end
	end

	// The first stage feeds only the second stage.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
			out_ff <= RST_VAL;
		end else begin
			s1_ff <= rawIn;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			out_ff <= nxt_out;
		end
	end

	assign stableOut = out_ff;
endmodule

/* hdl/supervisor_pkg.sv */
// Shared constants and carrier types for the processor supervisor block.
package supervisor_pkg;
	// System clock rate and the documented stretch time.
	localparam int CLK_HZ = 20_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int STRETCH_MS = 250;
	localparam int STRETCH_CYC = STRETCH_MS * CYC_PER_MS;
	// Debounce and watchdog times have no printed figure; plain defaults.
	localparam int DEBOUNCE_MS = 10;
	localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
	localparam int WDOG_MS = 1000;
	localparam int WDOG_CYC = WDOG_MS * CYC_PER_MS;
	localparam int CNT_W = 26;
	// Serial command byte layout.
	localparam int ADDR_W = 7;
	localparam int RW_BIT = 7;
	localparam int FRAME_BITS = 16;
	localparam logic [3:0] CMD_LAST = 4'h7;
	localparam logic [3:0] FRAME_LAST = 4'hf;
	// Synchroniser width and reset level of the sampled pins.
	localparam int SYNC_W = 7;
	localparam logic [SYNC_W-1:0] PIN_RST = 7'h3e;

	// Decoded command byte.
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
	} cmd_t;

	// Pins sampled into the system clock domain.
	typedef struct packed {
		logic frameTgl;
		logic kickN;
		logic resetPinN;
		logic ramSelN;
		logic upperN;
		logic lowerN;
		logic supplyFail;
	} pins_t;
endpackage

/* testbench/serial_host.sv */
// Host model: drives three-wire frames and resolves the shared data line.
`timescale 1ns/10ps
module serial_host (
	// Link pins.
	output logic sclk,
	output logic cs,
	output logic sdIn,
	input wire logic sdOut,
	input wire logic sdOe
);
	logic hostOe = 1'b0;
	logic hostBit = 1'b0;
	logic lastLvl = 1'b0;
	// A released line shows the inverse of its last level, never a held value.
	assign sdIn = sdOe ? sdOut : (hostOe ? hostBit : ~lastLvl);
	always @(posedge sclk) lastLvl <= sdIn;
	initial begin
		sclk = 1'b0;
		cs = 1'b0;
	end
	// Clock edges with chip select low, used only while the block is in reset.
	task automatic idle_edges(input int n);
		repeat (n) begin
			#7.5 sclk = 1'b1;
			#7.5 sclk = 1'b0;
		end
	endtask
	// frame drive: select held high, bits LSB first on rising edges.
	task automatic send(input logic [15:0] frame, input int nEdges, output logic [7:0] rd,
		output logic oeSeen);
		rd = 8'h00;
		oeSeen = 1'b0;
		cs = 1'b1;
		for (int i = 0; i < nEdges; i++) begin
			hostOe = !(i >= 8 && !frame[7]);
			hostBit = frame[i];
			#7.5 oeSeen = oeSeen | sdOe;
			if (i >= 8) rd[i-8] = sdIn;
			sclk = 1'b1;
			#7.5 sclk = 1'b0;
		end
		hostOe = 1'b0;
		#7.5 cs = 1'b0;
	endtask
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the processor supervisor block.
`timescale 1ns/10ps
module tb_top;
	localparam int ST = 200;
	localparam int DB = 20;
	localparam int WD = 500;
	logic clk = 1'b0, sys_rst = 1'b1, supplyFail = 1'b0, kickN = 1'b1, kickOn = 1'b1;
	logic btnN = 1'b1, ramN = 1'b1, upN = 1'b1, loN = 1'b1, rstOut, rstOe;
	logic lowN, highN, irq, sclk, cs, sdIn, sdOut, sdOe, cmdValid, oeSeen;
	logic [7:0] pend = 8'h00, en = 8'h00, cmdData, rd;
	logic [4:0] rows [8] = '{5'h03, 5'h0a, 5'h05, 5'h0f, 5'h10, 5'h1b, 5'h16, 5'h1c};
	logic [2:0] expd [8] = '{3'h1, 3'h2, 3'h4, 3'h7, 3'h6, 3'h7, 3'h6, 3'h6};
	supervisor_pkg::cmd_t cmdOut;
	int n_fail = 0, samples_checked = 0, vCnt = 0, v0, kickCnt = 0;
	wire rstPin = (rstOe | !btnN) ? 1'b0 : 1'b1;
	initial forever #25 clk = ~clk;
	cpu_supervisor_reset_ctl #(.STRETCH_CYC(ST), .DEBOUNCE_CYC(DB), .WDOG_CYC(WD)) DUT (
		.clk(clk), .sys_rst(sys_rst), .supplyFail(supplyFail), .watchdog_kick_n(kickN),
		.cpu_reset_in(rstPin), .cpu_reset_out(rstOut), .cpu_reset_oe(rstOe),
		.ram_select_in_n(ramN), .upper_byte_sel_n(upN), .lower_byte_sel_n(loN),
		.low_ram_select_n(lowN), .high_ram_select_n(highN), .irqPending(pend),
		.irqEnable(en), .irq_out(irq), .serial_clock_in(sclk), .serial_chip_sel(cs),
		.serial_data_in(sdIn), .serial_data_out(sdOut), .serial_data_oe(sdOe),
		.cmdOut(cmdOut), .cmdData(cmdData), .cmdValid(cmdValid));
	serial_host host (.sclk(sclk), .cs(cs), .sdIn(sdIn), .sdOut(sdOut), .sdOe(sdOe));
	// Count command pulses and kick the watchdog every 100 cycles while enabled.
	always @(posedge clk) if (cmdValid === 1'b1) vCnt <= vCnt + 1;
	always @(negedge clk) begin
		kickCnt <= (kickCnt + 1) % 100;
		kickN <= !(kickOn && kickCnt < 2);
	end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("Checked %0d, failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Waits for the reset drive to reach a level, bounded.
	task automatic wait_oe(input logic lvl, input int bound);
		for (int i = 0; i <= bound; i++) begin
			@(negedge clk);
			if (rstOe === lvl) return;
		end
		check("reset wait", rstOe, lvl);
		print_verdict();
	endtask
	// Checks the drive stays active before the stretch ends and drops just after.
	task automatic stretch_check(input int from);
		repeat (ST - 10 - from) @(negedge clk);
		check("stretch hold", rstOe, 1'b1);
		wait_oe(1'b0, 25);
	endtask
	task automatic frame(input logic [15:0] f, input int n, input logic [7:0] ec,
		input logic ev);
		logic [7:0] ed;
		v0 = vCnt;
		// A read shifts in the zeros the block drives, a write the host's byte.
		ed = f[7] ? f[15:8] : 8'h00;
		host.send(f, n, rd, oeSeen);
		repeat (20) @(negedge clk);
		check("cmd pulse", vCnt - v0, ev);
		if (ev) check("cmd", {cmdOut.write, cmdOut.addr, cmdData}, {ec, ed});
		check("data oe", oeSeen, ev && !f[7]);
		if (ev && !f[7]) check("read data", rd, 8'h00);
	endtask
	initial begin
		fork
			repeat (10) @(negedge clk);
			host.idle_edges(20);
		join
		sys_rst = 1'b0;
		// Power-up period counts as a reset.
		check("oe at release", rstOe, 1'b1);
		check("pin out", rstOut, 1'b0);
		stretch_check(0);
		for (int r = 0; r < 8; r++) begin
			{ramN, upN, loN} = rows[r][4:2];
			pend = rows[r][1] ? 8'h10 : 8'h00;
			en = rows[r][0] ? 8'h10 : 8'h01;
			repeat (8) @(negedge clk);
			check("ram and irq", {lowN, highN, irq}, expd[r]);
		end
		// supply fail holds reset, then stretches.
		supplyFail = 1'b1;
		wait_oe(1'b1, 8);
		repeat (30) @(negedge clk);
		check("fail hold", rstOe, 1'b1);
		supplyFail = 1'b0;
		stretch_check(0);
		// new cause in mid-stretch restarts the count.
		supplyFail = 1'b1;
		wait_oe(1'b1, 8);
		supplyFail = 1'b0;
		repeat (150) @(negedge clk);
		supplyFail = 1'b1;
		// A single-cycle pulse is rejected by the pin filter, so hold it three cycles.
		repeat (3) @(negedge clk);
		supplyFail = 1'b0;
		stretch_check(0);
		// an outside low on the reset pin acts as the button.
		// The pin must be seen high after our own drive before a press is armed.
		repeat (10) @(negedge clk);
		btnN = 1'b0;
		wait_oe(1'b1, DB + 12);
		btnN = 1'b1;
		stretch_check(0);
		// regular kicks keep reset off; stopping them times out.
		repeat (2 * WD) @(negedge clk);
		check("kicked", rstOe, 1'b0);
		// Stop just after a kick so the timeout is measured from a known point.
		for (int i = 0; i < 100 && kickCnt != 3; i++) @(negedge clk);
		kickOn = 1'b0;
		repeat (WD - 20) @(negedge clk);
		check("before timeout", rstOe, 1'b0);
		wait_oe(1'b1, 40);
		kickOn = 1'b1;
		stretch_check(0);
		// write, read and a short frame that is dropped.
		frame(16'h3c85, 16, 8'h85, 1'b1);
		frame(16'ha512, 16, 8'h12, 1'b1);
		frame(16'h00ff, 10, 8'h00, 1'b0);
		print_verdict();
	end
endmodule
